//--- bmc_pkg.sv
// bus matrix configuration block: register map, fields, resets, memory map
package bmc_pkg;
    // register byte offsets
    localparam logic [7:0] BMC_OFF_CONFIG = 8'h00;
    localparam logic [7:0] BMC_OFF_RAM_SIZE = 8'h04;
    localparam logic [7:0] BMC_OFF_USER_BASE = 8'h08;
    localparam logic [7:0] BMC_OFF_FLASH_SIZE = 8'h0C;
    localparam logic [7:0] BMC_OFF_IRQ_STATUS = 8'h10;
    localparam logic [7:0] BMC_OFF_IRQ_MASK = 8'h14;
    localparam int BMC_ADDR_W = 8;

    // configuration register fields
    localparam int BMC_CFG_ERR_SHARED = 20;
    localparam int BMC_CFG_ERR_DEBUG = 19;
    localparam int BMC_CFG_ERR_DMA = 18;
    localparam int BMC_CFG_ERR_CPU_DATA = 17;
    localparam int BMC_CFG_ERR_CPU_INSTR = 16;
    localparam int BMC_CFG_ERR_LSB = 16;
    localparam int BMC_CFG_WAIT = 6;
    localparam int BMC_CFG_ARB_LSB = 0;
    localparam int BMC_ARB_W = 3;
    localparam logic [31:0] BMC_CFG_WMASK = 32'h001F0047;
    localparam logic [31:0] BMC_CFG_RESET = 32'h001F0041;

    // arbitration codes
    localparam logic [2:0] BMC_ARB_MODE0 = 3'h0;
    localparam logic [2:0] BMC_ARB_MODE1 = 3'h1;
    localparam logic [2:0] BMC_ARB_MODE2 = 3'h2;

    // user program base: bits 19..11 writable, 2 KB steps
    localparam logic [31:0] BMC_UBASE_WMASK = 32'h000FF800;
    localparam logic [31:0] BMC_UBASE_RESET = 32'h00000000;

    // sizes in bytes
    localparam logic [31:0] BMC_RAM_SIZE_DEF = 32'h00001000;
    localparam logic [31:0] BMC_FLASH_SIZE_DEF = 32'h00004000;

    // initiator indexes, one error enable and status bit each
    localparam int BMC_NUM_INIT = 5;
    localparam int BMC_INI_CPU_INSTR = 0;
    localparam int BMC_INI_CPU_DATA = 1;
    localparam int BMC_INI_DMA = 2;
    localparam int BMC_INI_DEBUG = 3;
    localparam int BMC_INI_SHARED = 4;
    localparam logic [31:0] BMC_IRQ_RESET = 32'h00000000;

    // physical memory map used by the unmapped-address decode
    localparam logic [31:0] BMC_PHYS_MASK = 32'h1FFFFFFF;
    localparam logic [31:0] BMC_RAM_BASE = 32'h00000000;
    localparam logic [31:0] BMC_FLASH_BASE = 32'h1D000000;
    localparam logic [31:0] BMC_PERIPH_BASE = 32'h1F800000;
    localparam logic [31:0] BMC_PERIPH_SIZE = 32'h00100000;
    localparam logic [31:0] BMC_BOOT_BASE = 32'h1FC00000;
    localparam logic [31:0] BMC_BOOT_SIZE = 32'h00000C00;
endpackage

//--- bmc_addr_decode.sv
// per-initiator unmapped-address decode against the memory map
`timescale 1ns/1ns
module bmc_addr_decode #(
    parameter int NUM_INIT = bmc_pkg::BMC_NUM_INIT
) (
    // accesses, one per initiator
    input wire logic [NUM_INIT-1:0] acc_valid,
    input wire logic [NUM_INIT*32-1:0] acc_addr,
    // installed sizes
    input wire logic [31:0] ram_size,
    input wire logic [31:0] flash_size,
    // one bit per initiator, high for an unmapped access
    output logic [NUM_INIT-1:0] unmapped
);
    import bmc_pkg::*;

    function automatic logic in_region(input logic [31:0] a,
                                       input logic [31:0] base,
                                       input logic [31:0] size);
        logic [32:0] top;
        top = {1'b0, base} + {1'b0, size};
        in_region = (a >= base) && ({1'b0, a} < top);
    endfunction

    genvar i;
    generate
        for (i = 0; i < NUM_INIT; i++) begin : g_init
            logic [31:0] phys;
            logic mapped;
            assign phys = acc_addr[i*32 +: 32] & BMC_PHYS_MASK;
            assign mapped = in_region(phys, BMC_RAM_BASE, ram_size)
                || in_region(phys, BMC_FLASH_BASE, flash_size)
                || in_region(phys, BMC_PERIPH_BASE, BMC_PERIPH_SIZE)
                || in_region(phys, BMC_BOOT_BASE, BMC_BOOT_SIZE);
            assign unmapped[i] = acc_valid[i] && !mapped;
        end
    endgenerate
endmodule

//--- bmc_regs.sv
// bus matrix configuration and status registers with APB access
//
// Summary of operation
// - shared bus enable bit 20 gates bus errors on its unmapped accesses
// - bit 19 enables bus errors for debug unit unmapped accesses
// - bit 18 enables bus errors for DMA unmapped accesses
// - bit 17 enables CPU data bus errors, suppressed in debug mode
// - bit 16 enables CPU fetch bus errors, suppressed in debug mode
// - bit 6 set adds one RAM address setup wait state for CPU
// - arbitration field codes 000, 001, 010 select modes; 001 default
// - unimplemented bits ignore writes and read as zero
// - data RAM size register is read-only fixed byte count
// - user base bits 19 to 11 are software writable
// - user base bits 10 to 0 read zero, 2 KB steps
// - reset clears user base, whole region kernel mode
`timescale 1ns/1ns
module bmc_regs
    import bmc_pkg::*;
#(
    parameter logic [31:0] RAM_SIZE = bmc_pkg::BMC_RAM_SIZE_DEF,
    parameter logic [31:0] FLASH_SIZE = bmc_pkg::BMC_FLASH_SIZE_DEF
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [bmc_pkg::BMC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // initiator accesses
    input wire logic [bmc_pkg::BMC_NUM_INIT-1:0] acc_valid,
    input wire logic [bmc_pkg::BMC_NUM_INIT*32-1:0] acc_addr,
    input wire logic cpu_debug_mode,
    // bus error pulses, one per initiator
    output logic [bmc_pkg::BMC_NUM_INIT-1:0] bus_err,
    // matrix control
    output logic ram_setup_wait_state,
    output logic [bmc_pkg::BMC_ARB_W-1:0] arbitration_select,
    output logic [31:0] user_flash_program_base,
    // interrupt
    output logic irq
);
    typedef struct packed {
        logic [31:0] config_r;
        logic [31:0] ubase_r;
        logic [BMC_NUM_INIT-1:0] status_r;
        logic [BMC_NUM_INIT-1:0] mask_r;
        logic [BMC_NUM_INIT-1:0] snap_r;
        logic [31:0] prdata_r;
        logic slverr_r;
        logic [BMC_NUM_INIT-1:0] err_r;
    } bmc_state_t;

    localparam bmc_state_t BMC_STATE_RESET = '{
        config_r: BMC_CFG_RESET,
        ubase_r: BMC_UBASE_RESET,
        status_r: BMC_IRQ_RESET[BMC_NUM_INIT-1:0],
        mask_r: BMC_IRQ_RESET[BMC_NUM_INIT-1:0],
        snap_r: BMC_IRQ_RESET[BMC_NUM_INIT-1:0],
        prdata_r: 32'h00000000,
        slverr_r: 1'b0,
        err_r: '0
    };

    bmc_state_t st_r;
    bmc_state_t st_nxt;
    logic [BMC_NUM_INIT-1:0] unmapped;
    logic [BMC_NUM_INIT-1:0] err_en;
    logic [31:0] bmask;
    logic setup_ph;
    logic access_ph;
    logic hit;
    logic [31:0] rd_val;

    bmc_addr_decode #(
        .NUM_INIT(BMC_NUM_INIT)
    ) u_decode (
        .acc_valid(acc_valid),
        .acc_addr(acc_addr),
        .ram_size(RAM_SIZE),
        .flash_size(FLASH_SIZE),
        .unmapped(unmapped)
    );

    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;

    // byte enables to a bit mask
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            bmask[b*8 +: 8] = {8{pstrb[b]}};
        end
    end

    // per-initiator enable, debug mode masks the two cpu ports
    always_comb begin
        err_en = st_r.config_r[BMC_CFG_ERR_LSB +: BMC_NUM_INIT];
        if (cpu_debug_mode) begin
            err_en[BMC_INI_CPU_INSTR] = 1'b0;
            err_en[BMC_INI_CPU_DATA] = 1'b0;
        end
    end

    // read mux, decoded in the setup cycle
    always_comb begin
        hit = 1'b1;
        rd_val = 32'h00000000;
        unique case (paddr)
            BMC_OFF_CONFIG: begin
                rd_val = st_r.config_r & BMC_CFG_WMASK;
            end
            BMC_OFF_RAM_SIZE: begin
                rd_val = RAM_SIZE;
            end
            BMC_OFF_USER_BASE: begin
                rd_val = st_r.ubase_r & BMC_UBASE_WMASK;
            end
            BMC_OFF_FLASH_SIZE: begin
                rd_val = FLASH_SIZE;
            end
            BMC_OFF_IRQ_STATUS: begin
                rd_val[BMC_NUM_INIT-1:0] = st_r.status_r;
            end
            BMC_OFF_IRQ_MASK: begin
                rd_val[BMC_NUM_INIT-1:0] = st_r.mask_r;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.err_r = unmapped & err_en;

        // read data and error are captured at setup, held through access
        if (setup_ph) begin
            st_nxt.prdata_r = pwrite ? 32'h00000000 : rd_val;
            st_nxt.slverr_r = !hit;
            st_nxt.snap_r = '0;
            if (!pwrite && paddr == BMC_OFF_IRQ_STATUS) begin
                st_nxt.snap_r = st_r.status_r;
            end
        end

        if (access_ph && pwrite) begin
            unique case (paddr)
                BMC_OFF_CONFIG: begin
                    // reserved arbitration codes are stored as written
                    st_nxt.config_r = ((st_r.config_r & ~bmask)
                        | (pwdata & bmask)) & BMC_CFG_WMASK;
                end
                BMC_OFF_USER_BASE: begin
                    st_nxt.ubase_r = ((st_r.ubase_r & ~bmask)
                        | (pwdata & bmask))
                        & BMC_UBASE_WMASK;
                end
                BMC_OFF_IRQ_MASK: begin
                    if (pstrb[0]) begin
                        st_nxt.mask_r = pwdata[BMC_NUM_INIT-1:0];
                    end
                end
                default: begin
                    st_nxt.slverr_r = st_r.slverr_r;
                end
            endcase
        end

        // read clears only what was seen; new events win over the clear
        if (access_ph && !pwrite && paddr == BMC_OFF_IRQ_STATUS) begin
            st_nxt.status_r = st_r.status_r & ~st_r.snap_r;
        end
        st_nxt.status_r = st_nxt.status_r | unmapped;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= BMC_STATE_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.prdata_r;
    assign pready = 1'b1;
    assign pslverr = access_ph && st_r.slverr_r;
    assign bus_err = st_r.err_r;
    assign ram_setup_wait_state = st_r.config_r[BMC_CFG_WAIT];
    assign arbitration_select = st_r.config_r[BMC_CFG_ARB_LSB +: BMC_ARB_W];
    assign user_flash_program_base = st_r.ubase_r;
    assign irq = |(st_r.status_r & st_r.mask_r);
endmodule

//--- bmc_regs_assertions.sv
// port checks for the bus matrix configuration block
`timescale 1ns/1ns
module bmc_regs_assertions
    import bmc_pkg::*;
#(
    parameter logic [31:0] RAM_SIZE = 32'h00001000
) (
    // clock, reset, apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [bmc_pkg::BMC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    // initiators and outputs
    input wire logic [4:0] acc_valid,
    input wire logic cpu_debug_mode,
    input wire logic [4:0] bus_err,
    input wire logic ram_setup_wait_state,
    input wire logic [2:0] arbitration_select,
    input wire logic [31:0] user_flash_program_base,
    input wire logic irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr;
    logic rd;
    assign wr = psel && penable && pwrite && pstrb == 4'hF;
    assign rd = psel && penable && !pwrite;
    AST_ERR_CAUSE: assert property (
        (bus_err & ~$past(acc_valid)) == 5'h0)
        else $error("error pulse without access");
    AST_ERR_DEBUG: assert property (
        $past(cpu_debug_mode) |-> !bus_err[1:0])
        else $error("cpu error in debug mode");
    AST_WAIT: assert property (wr && paddr == BMC_OFF_CONFIG
        |=> ram_setup_wait_state == $past(pwdata[6]))
        else $error("wait bit");
    AST_ARB: assert property (wr && paddr == BMC_OFF_CONFIG
        |=> arbitration_select == $past(pwdata[2:0]))
        else $error("arb field");
    AST_BASE: assert property (
        wr && paddr == BMC_OFF_USER_BASE |=>
        user_flash_program_base == ($past(pwdata) & 32'h000FF800))
        else $error("user base write");
    AST_BASE_LOW: assert property (
        user_flash_program_base[10:0] == 11'h0)
        else $error("user base low bits");
    AST_RAMSZ: assert property (rd && paddr == BMC_OFF_RAM_SIZE
        |-> prdata == RAM_SIZE) else $error("ram size");
    AST_CFG_RSV: assert property (rd && paddr == BMC_OFF_CONFIG
        |-> (prdata & 32'hFFE0FFB8) == 32'h0) else $error("config reserved");
    AST_RST: assert property ($rose(presetn)
        |-> arbitration_select == 3'h1 && user_flash_program_base == 32'h0)
        else $error("reset values");
    COV_ERR: cover property (bus_err != 5'h0);
    COV_IRQ: cover property ($fell(irq));
    COV_WR: cover property (wr && paddr == BMC_OFF_USER_BASE);
endmodule

//--- bmc_init_model.sv
// bus initiator model: one access lane per initiator
`timescale 1ns/1ns
module bmc_init_model
    import bmc_pkg::*;
(
    // clock and bench control
    input wire logic pclk,
    input wire logic [bmc_pkg::BMC_NUM_INIT-1:0] go,
    input wire logic bad,
    // accesses toward the matrix
    output logic [bmc_pkg::BMC_NUM_INIT-1:0] acc_valid,
    output logic [bmc_pkg::BMC_NUM_INIT*32-1:0] acc_addr
);
    always_ff @(posedge pclk) begin
        acc_valid <= go;
        // idle lanes carry fresh junk, never a stale address
        for (int i = 0; i < BMC_NUM_INIT; i++) begin
            acc_addr[i*32+:32] <= bad ? 32'h10000000 | ($urandom & 32'hFFFFFF)
                : $urandom & 32'hFFF;
        end
    end
endmodule

//--- bmc_regs_test.sv
// self-checking bench for the bus matrix configuration block
`timescale 1ns/1ns
module bmc_regs_test;
    import bmc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, dbg = 1'b0, bad = 1'b0, pready, pslverr, irq, wst;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, ubase, rd, d;
    logic [4:0] go = 5'h0, acc_valid, bus_err;
    logic [159:0] acc_addr;
    logic [2:0] arb;
    logic perr;
    int bad_count = 0, total_checks = 0;
    bmc_regs u_bmc_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .acc_valid(acc_valid), .acc_addr(acc_addr), .cpu_debug_mode(dbg),
        .bus_err(bus_err), .ram_setup_wait_state(wst),
        .arbitration_select(arb), .user_flash_program_base(ubase), .irq(irq));
    bmc_init_model u_bmc_init_model (.pclk(pclk), .go(go), .bad(bad),
        .acc_valid(acc_valid), .acc_addr(acc_addr));
    initial forever #5 pclk = ~pclk;
    task final_report;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            $display("mismatch at %0t: no ready", $time);
            bad_count++;
            final_report;
        end else begin
            @(posedge pclk);
        end
    endtask
    function logic [4:0] want(logic [4:0] g, logic b, logic dg,
        logic [4:0] en);
        return b ? g & en & (dg ? 5'h1C : 5'h1F) : 5'h0;
    endfunction
    task acc(input logic [4:0] g, input logic b, input logic dg,
        input logic [4:0] en);
        logic [31:0] w;
        logic [31:0] g32;
        w = {27'h0, want(g, b, dg, en)};
        go <= g;
        bad <= b;
        dbg <= dg;
        @(posedge pclk);
        go <= 5'h0;
        @(posedge pclk);
        #1 g32 = {27'h0, bus_err};
        chk(g32 & 32'h1C, w & 32'h1C);
        chk(g32 & 32'h3, w & 32'h3);
        chk(g32, w);
        @(posedge pclk);
    endtask
    task errs(input logic [4:0] en);
        for (int k = 0; k < 10; k++) acc(5'h1 << k / 2, 1'b1, k[0], en);
        acc(5'h1F, 1'b0, 1'b0, en);
    endtask
    initial begin
        void'($urandom(32'hFDD06451));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, BMC_OFF_CONFIG, 0);
        chk(rd, 32'h001F0041);
        apb(1'b0, BMC_OFF_RAM_SIZE, 0);
        chk(rd, 32'h00001000);
        apb(1'b0, BMC_OFF_USER_BASE, 0);
        chk(rd, 32'h0);
        errs(5'h1F);
        repeat (6) begin
            d = ($urandom & 32'hFFFFFFF8) | $urandom_range(2);
            apb(1'b1, BMC_OFF_CONFIG, d);
            chk({29'h0, arb}, {29'h0, d[2:0]});
            chk({31'h0, wst}, {31'h0, d[6]});
            apb(1'b0, BMC_OFF_CONFIG, 0);
            chk(rd, d & 32'h001F0047);
            errs(d[20:16]);
            d = $urandom_range(32'h4000);
            apb(1'b1, BMC_OFF_USER_BASE, d);
            chk(ubase, d & 32'h000FF800);
            apb(1'b0, BMC_OFF_USER_BASE, 0);
            chk(rd, d & 32'h000FF800);
            apb(1'b1, BMC_OFF_RAM_SIZE, $urandom);
            apb(1'b0, BMC_OFF_RAM_SIZE, 0);
            chk(rd, 32'h00001000);
        end
        // mid-run reset must clear the user base again
        apb(1'b1, BMC_OFF_USER_BASE, 32'h00002800);
        chk(ubase, 32'h00002800);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(ubase, 32'h0);
        apb(1'b0, BMC_OFF_CONFIG, 0);
        chk(rd, 32'h001F0041);
        apb(1'b1, BMC_OFF_CONFIG, 0);
        apb(1'b1, BMC_OFF_IRQ_MASK, 32'h4);
        apb(1'b0, BMC_OFF_IRQ_MASK, 0);
        chk(rd, 32'h4);
        apb(1'b0, BMC_OFF_IRQ_STATUS, 0);
        acc(5'h04, 1'b1, 1'b0, 5'h0);
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, BMC_OFF_IRQ_STATUS, 0);
        chk(rd, 32'h4);
        chk({31'h0, irq}, 32'h0);
        acc(5'h08, 1'b1, 1'b0, 5'h0);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, BMC_OFF_FLASH_SIZE, 0);
        chk(rd, 32'h00004000);
        chk({31'h0, perr}, 32'h0);
        apb(1'b0, 8'h20, 0);
        chk(rd, 32'h0);
        chk({31'h0, perr}, 32'h1);
        final_report;
    end
endmodule
bind bmc_regs bmc_regs_assertions #(.RAM_SIZE(RAM_SIZE)) u_bmc_regs_assertions (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .acc_valid(acc_valid), .cpu_debug_mode(cpu_debug_mode),
    .bus_err(bus_err), .ram_setup_wait_state(ram_setup_wait_state),
    .arbitration_select(arbitration_select), .irq(irq),
    .user_flash_program_base(user_flash_program_base));
